// >>> logic/slm_pkg.sv
// Constants, field layout and types of the link error monitor.
// Assumes a single 100 MHz clock and a byte-wide register port.
// Operation
// RULE_01 - Repeat-pattern enable runs a per-lane check against the long test pattern.
// RULE_02 - Software enables the repeat-pattern test only with link test mode off.
// RULE_03 - Software writes configuration fields only while the receiver is in soft reset.
// RULE_04 - Queued mode off: simultaneous errors on several lanes form one event.
// RULE_05 - Queued mode on: every detected error is counted, then signalled in turn.
// RULE_06 - Auto-clear resets only the counter that caused the sync request.
// RULE_07 - Eight-bit multiframe group count field, reset value one.
// RULE_08 - Software writes only one, two or four to the multiframe count.
// RULE_09 - Per lane, three error kinds are counted against an eight-bit threshold, reset 0xff.
// RULE_10 - A count equal to threshold raises interrupt, sync request or both per masks.
// RULE_11 - A counter at threshold with its sync enable set asserts sync request.
// RULE_12 - Sync enable bit 2 is bad disparity, bit 1 not-in-table, bit 0 control char.
// RULE_13 - Soft reset bit is a synchronous active-high reset, default zero.
// RULE_14 - Link test mode expects endless alignment sequence after code group sync.
// RULE_15 - Counters are at least eight bits and stop at the threshold.
package slm_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [11:0] ADDR_SOFT_RST = 12'h475;
  localparam logic [11:0] ADDR_CTRL = 12'h477;
  localparam logic [11:0] ADDR_MF_CNT = 12'h478;
  localparam logic [11:0] ADDR_THR = 12'h47c;
  localparam logic [11:0] ADDR_SMASK = 12'h47d;
  // ==========================================================
  // Field positions
  localparam int SOFT_RST_BIT = 3;
  localparam int LINK_TEST_BIT = 7;
  localparam int REPEAT_TEST_BIT = 5;
  localparam int QUEUED_BIT = 4;
  localparam int AUTO_CLR_BIT = 3;
  localparam logic [7:0] CTRL_RW_MASK = 8'hb8;
  // Counter order inside a lane
  localparam int ERR_DISP = 0;
  localparam int ERR_TABLE = 1;
  localparam int ERR_CTRL = 2;
  localparam int NUM_ERR = 3;
  // ==========================================================
  // Reset values
  localparam logic SOFT_RST_RST = 1'b0;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] MF_CNT_RST = 8'h01;
  localparam logic [7:0] THR_RST = 8'hff;
  localparam logic [2:0] SMASK_RST = 3'h7;
  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SYNC_ASSERT_NS = 40;
  localparam int SYNC_ASSERT_CYC = (SYNC_ASSERT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Test pattern, eight octets, arbitrary values
  localparam int TEST_PAT_LEN = 8;
  localparam logic [63:0] TEST_PAT = 64'h5a_c3_96_3c_a5_0f_f0_69;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {SY_IDLE, SY_ASSERT, SY_GAP} slm_sync_state_t;
endpackage

// >>> logic/slm_lane_if.sv
// Bundle between the monitor and one lane's counter group.
// Assumes the monitor drives strobes and reads threshold flags.
`timescale 1ns/1ns
`default_nettype none
interface slm_lane_if #(parameter int CNT_W = 8);
  logic [2:0] err;
  logic [2:0] clr;
  logic [CNT_W-1:0] thr;
  logic srst;
  logic [2:0] at_thr;
  // Counter side
  modport ctr (input err, input clr, input thr, input srst, output at_thr);
  // Monitor side
  modport mon (output err, output clr, output thr, output srst, input at_thr);
endinterface
`default_nettype wire

// >>> logic/slm_lane_counter.sv
// Three saturating error counters of one lane.
// Assumes error strobes are one-cycle pulses on clk_i.
`timescale 1ns/1ns
`default_nettype none
module slm_lane_counter
  import slm_pkg::*;
#(
  parameter int CNT_W = 8
)
(
  // Clock
  input wire logic clk_i,
  // Lane bundle
  slm_lane_if.ctr lane
);
  // ==========================================================
  // Counters
  logic [CNT_W-1:0] cnt_ff [NUM_ERR];
  logic [2:0] at_ff;

  for (genvar k = 0; k < NUM_ERR; k++)
  begin : g_cnt
    logic [CNT_W-1:0] nxt_cnt;
    wire at_now = cnt_ff[k] == lane.thr;
    // Clear first, then count until the threshold
    assign nxt_cnt = lane.clr[k] ? CNT_W'(lane.err[k]) :
                     (lane.err[k] && !at_now) ? cnt_ff[k] + 1'b1 : // RULE_15
                     cnt_ff[k];
    // Count and compare per kind
    always_ff @(posedge clk_i)
    begin
      if (lane.srst)
      begin
        cnt_ff[k] <= '0;
        at_ff[k] <= 1'b0;
      end
      else
      begin
        cnt_ff[k] <= nxt_cnt; // RULE_09
        at_ff[k] <= nxt_cnt == lane.thr; // RULE_09
      end
    end
  end

  assign lane.at_thr = at_ff;
endmodule // slm_lane_counter
`default_nettype wire

// >>> logic/slm_error_monitor.sv
// Error monitor and sync request control of the link receiver.
// Assumes per-lane error strobes and data from the decoder, one clock.
`timescale 1ns/1ns
`default_nettype none
module slm_error_monitor
  import slm_pkg::*;
#(
  parameter int NUM_LANES = 8,
  parameter int CNT_W = 8
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [11:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // Lane inputs
  input wire logic [NUM_LANES*3-1:0] lane_err_i,
  input wire logic [NUM_LANES*8-1:0] lane_data_i,
  input wire logic [NUM_LANES-1:0] lane_valid_i,
  input wire logic [2:0] irq_mask_i,
  // Status and link outputs
  output logic sync_request_out_o,
  output logic irq_o,
  output logic [NUM_LANES*3-1:0] threshold_hit_o,
  output logic [7:0] alignment_multiframe_groups_o,
  output logic link_test_mode_o,
  output logic [NUM_LANES-1:0] lane_test_fail_o
);
  localparam int NHIT = NUM_LANES * 3;

  // ==========================================================
  // Parameter checks
  if (NUM_LANES < 1 || NUM_LANES > 8)
  begin : g_bad_lanes
    $error("NUM_LANES must be 1 to 8");
  end
  if (CNT_W < 8 || CNT_W > 16)
  begin : g_bad_cnt
    $error("CNT_W must be 8 to 16");
  end

  // ==========================================================
  // Registers
  logic soft_rst_ff;
  logic [7:0] ctrl_ff;
  logic [7:0] mf_cnt_ff;
  logic [7:0] thr_ff;
  logic [2:0] smask_ff;
  logic [7:0] rdata_ff;
  logic rvalid_ff;

  // Soft reset joins the port reset for the datapath
  wire srst = rst_i | soft_rst_ff; // RULE_13
  wire wr_srst = reg_wr_i && reg_addr_i == ADDR_SOFT_RST;
  wire wr_ctrl = reg_wr_i && reg_addr_i == ADDR_CTRL;
  wire wr_mf_cnt = reg_wr_i && reg_addr_i == ADDR_MF_CNT;
  wire wr_thr = reg_wr_i && reg_addr_i == ADDR_THR;
  wire wr_smask = reg_wr_i && reg_addr_i == ADDR_SMASK;
  wire link_test = ctrl_ff[LINK_TEST_BIT];
  wire queued = ctrl_ff[QUEUED_BIT];
  wire auto_clr = ctrl_ff[AUTO_CLR_BIT];
  wire test_act = ctrl_ff[REPEAT_TEST_BIT] & ~link_test;

  // Read selection, unmapped reads zero
  wire [7:0] rd_mux =
    (reg_addr_i == ADDR_SOFT_RST) ? 8'(soft_rst_ff) << SOFT_RST_BIT :
    (reg_addr_i == ADDR_CTRL) ? ctrl_ff :
    (reg_addr_i == ADDR_MF_CNT) ? mf_cnt_ff :
    (reg_addr_i == ADDR_THR) ? thr_ff :
    (reg_addr_i == ADDR_SMASK) ? {5'h00, smask_ff} : 8'h00;

  // Configuration, cleared by the port reset only
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      soft_rst_ff <= SOFT_RST_RST;
      ctrl_ff <= CTRL_RST;
      mf_cnt_ff <= MF_CNT_RST; // RULE_07
      thr_ff <= THR_RST; // RULE_09
      smask_ff <= SMASK_RST;
    end
    else
    begin
      if (wr_srst)
        soft_rst_ff <= reg_wdata_i[SOFT_RST_BIT]; // RULE_13
      if (wr_ctrl)
        ctrl_ff <= reg_wdata_i & CTRL_RW_MASK;
      if (wr_mf_cnt)
        mf_cnt_ff <= reg_wdata_i; // RULE_07
      if (wr_thr)
        thr_ff <= reg_wdata_i;
      if (wr_smask)
        smask_ff <= reg_wdata_i[2:0];
    end
  end

  // Read answer one cycle after the strobe
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      rdata_ff <= reg_rd_i ? rd_mux : 8'h00;
      rvalid_ff <= reg_rd_i;
    end
  end

  // ==========================================================
  // Lane counters
  logic [NHIT-1:0] at_all;
  logic [NHIT-1:0] prev_ff;
  logic [NHIT-1:0] new_hit;
  logic [NHIT-1:0] sync_hit;
  // Sync enables brought into counter order, reversed
  wire [2:0] sync_en = {smask_ff[0], smask_ff[1], smask_ff[2]}; // RULE_12

  for (genvar l = 0; l < NUM_LANES; l++)
  begin : g_lane
    slm_lane_if #(.CNT_W(CNT_W)) bus ();
    assign bus.err = lane_err_i[l*3 +: 3];
    assign bus.thr = CNT_W'(thr_ff);
    assign bus.srst = srst;
    // Auto-clear only the counters that raised the request
    assign bus.clr = auto_clr ? sync_hit[l*3 +: 3] : 3'h0; // RULE_06
    assign at_all[l*3 +: 3] = bus.at_thr;
    assign sync_hit[l*3 +: 3] = new_hit[l*3 +: 3] & sync_en; // RULE_11
    slm_lane_counter #(.CNT_W(CNT_W)) u_cnt (
      .clk_i(clk_i),
      .lane(bus)
    );
  end

  assign new_hit = at_all & ~prev_ff;

  // Ones count of fresh sync hits
  function automatic logic [7:0] count_ones(input logic [NHIT-1:0] v);
    logic [7:0] n;
    n = 8'h00;
    for (int i = 0; i < NHIT; i++)
      n = n + 8'(v[i]);
    return n;
  endfunction

  // ==========================================================
  // Sync request scheduler
  slm_sync_state_t state_ff;
  slm_sync_state_t nxt_state;
  logic [7:0] pend_ff;
  logic [7:0] nxt_pend;
  logic [7:0] pulse_ff;
  logic sync_ff;
  logic irq_ff;
  wire [7:0] n_hit = count_ones(sync_hit);
  // Queued mode adds every hit, else one per cycle of hits
  wire [7:0] n_add = queued ? n_hit : 8'(|sync_hit); // RULE_04 RULE_05
  wire take = state_ff == SY_IDLE && pend_ff != 8'h00;
  wire [8:0] pend_sum = 9'(pend_ff) + 9'(n_add) - 9'(take);
  wire pulse_done = pulse_ff == 8'(SYNC_ASSERT_CYC - 1);
  wire irq_any = |(at_all & {NUM_LANES{irq_mask_i}}); // RULE_10

  // Pending events saturate at 255, further hits are then lost
  assign nxt_pend = pend_sum[8] ? 8'hff : pend_sum[7:0]; // RULE_05

  // One fixed pulse per event, two low cycles (gap and idle) between pulses
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      SY_IDLE:
        if (take)
          nxt_state = SY_ASSERT; // RULE_11
      SY_ASSERT:
        if (pulse_done)
          nxt_state = SY_GAP;
      SY_GAP:
        nxt_state = SY_IDLE;
      default:
        nxt_state = SY_IDLE;
    endcase
  end

  // Scheduler state
  always_ff @(posedge clk_i)
  begin
    if (srst)
    begin
      state_ff <= SY_IDLE;
      pend_ff <= 8'h00;
      pulse_ff <= 8'h00;
      prev_ff <= '0;
      sync_ff <= 1'b0;
      irq_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      pend_ff <= nxt_pend;
      pulse_ff <= (state_ff == SY_ASSERT) ? pulse_ff + 8'h01 : 8'h00;
      prev_ff <= at_all;
      sync_ff <= nxt_state == SY_ASSERT; // RULE_10
      irq_ff <= irq_any; // RULE_10
    end
  end

  // ==========================================================
  // Repeat-pattern test per lane
  logic [NUM_LANES-1:0] fail_ff;
  logic [NUM_LANES-1:0] mis;
  for (genvar l = 0; l < NUM_LANES; l++)
  begin : g_test
    logic [2:0] ptr_ff;
    wire [7:0] exp_oct = TEST_PAT[ptr_ff*8 +: 8];
    assign mis[l] = lane_data_i[l*8 +: 8] != exp_oct;
    // Walk the pattern, flag any mismatch sticky
    always_ff @(posedge clk_i)
    begin
      if (srst || !test_act)
      begin
        ptr_ff <= 3'h0;
        fail_ff[l] <= 1'b0;
      end
      else if (lane_valid_i[l])
      begin
        ptr_ff <= ptr_ff + 3'h1;
        fail_ff[l] <= fail_ff[l] | mis[l]; // RULE_01
      end
    end
  end

  // Mode flag toward the alignment logic
  logic link_test_ff;
  always_ff @(posedge clk_i)
  begin
    if (srst)
      link_test_ff <= 1'b0;
    else
      link_test_ff <= link_test; // RULE_14
  end

  // ==========================================================
  // Outputs
  assign reg_rdata_o = rdata_ff;
  assign reg_rvalid_o = rvalid_ff;
  assign sync_request_out_o = sync_ff;
  assign irq_o = irq_ff;
  assign threshold_hit_o = prev_ff;
  assign alignment_multiframe_groups_o = mf_cnt_ff;
  assign link_test_mode_o = link_test_ff;
  assign lane_test_fail_o = fail_ff;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst);

  a_sync_pulse_len: assert property ($rose(sync_ff) |-> sync_ff[*4] ##1 !sync_ff) // RULE_11
    else $error("sync pulse length wrong");
  a_single_event: assert property ( // RULE_04
    !queued && pend_ff == 8'h00 && |sync_hit |=> pend_ff == 8'h01)
    else $error("simultaneous errors not merged");
  a_queue_count: assert property ( // RULE_05
    queued && pend_ff == 8'h00 && |sync_hit |=> pend_ff == $past(n_hit))
    else $error("queued errors miscounted");
  a_auto_clear: assert property ( // RULE_06
    auto_clr && |sync_hit && thr_ff > 8'h01 |=> (at_all & $past(sync_hit)) == '0)
    else $error("causing counter not cleared");
  a_sync_start: assert property (take |=> sync_ff ##1 sync_ff) // RULE_11
    else $error("pending event not signalled");
  a_mask_order: assert property (new_hit[ERR_DISP] && !smask_ff[2] |-> !sync_hit[ERR_DISP]) // RULE_12
    else $error("sync enable order wrong");
  a_irq_level: assert property (irq_any && !$rose(srst) |=> irq_ff) // RULE_10
    else $error("interrupt missing at threshold");
  a_mf_count_write: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_07
    wr_mf_cnt && !rst_i |=> mf_cnt_ff == $past(reg_wdata_i))
    else $error("multiframe count not stored");
  a_test_fail: assert property ( // RULE_01
    test_act && |(lane_valid_i & mis) |=> test_act |->
    (fail_ff & $past(lane_valid_i & mis)) == $past(lane_valid_i & mis))
    else $error("pattern mismatch not flagged");
  a_soft_reset: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_13
    soft_rst_ff |=> !sync_ff && pend_ff == 8'h00)
    else $error("soft reset did not clear state");
  a_sync_gap: assert property ($fell(sync_ff) |-> !sync_ff ##1 !sync_ff) // RULE_05
    else $error("no gap between sync pulses");
  a_irq_quiet: assert property (!irq_any |=> !irq_ff) // RULE_10
    else $error("interrupt without threshold hit");
  a_masked_hit: assert property ( // RULE_11
    |new_hit && sync_hit == '0 && pend_ff == 8'h00 |=> pend_ff == 8'h00)
    else $error("masked hit made an event");

  c_queued_multi: cover property (queued && n_hit > 8'h01);
  c_auto_clear: cover property (auto_clr && |sync_hit);
  c_test_fail: cover property ($rose(|fail_ff));
  c_masked_hit: cover property (|new_hit && sync_hit == '0);
endmodule // slm_error_monitor
`default_nettype wire

// >>> sim/slm_framer_model.sv
// Framer model: sends the test pattern on lanes 0 and 1, with one bit
// flipped on lane 1, and counts sync request pulses and their widths.
// Assumes one rising-edge clock shared with the monitor.
`timescale 1ns/1ns
`default_nettype none
module slm_framer_model
  import slm_pkg::*;
(
  // Clock and control
  input wire logic clk_i,
  input wire logic en_i,
  input wire logic sync_i,
  // Lane drive and observation
  output logic [15:0] data_o,
  output logic [1:0] valid_o,
  output logic [7:0] pulse_cnt_o = 8'h00,
  output logic width_bad_o = 1'b0
);
  int idx = 0;
  int run = 0;
  logic [7:0] oct;
  // ==========
  // Pattern octets in turn, inverted while idle
  assign oct = TEST_PAT[8*idx +: 8];
  assign valid_o = {en_i, en_i};
  assign data_o = en_i ? {oct ^ 8'h01, oct} : {~oct, oct ^ 8'hff};
  // Index restarts at 0 whenever the test is off
  always @(posedge clk_i)
  begin
    idx <= en_i ? (idx + 1) % TEST_PAT_LEN : 0;
  end
  // Pulse count at each fall, width checked
  always @(posedge clk_i)
  begin
    if (sync_i === 1'b1)
      run <= run + 1;
    else if (run != 0)
    begin
      if (run != SYNC_ASSERT_CYC)
        width_bad_o <= 1'b1;
      pulse_cnt_o <= pulse_cnt_o + 8'h01;
      run <= 0;
    end
  end
endmodule // slm_framer_model
`default_nettype wire

// >>> sim/tb_serdes_link_error_monitor.sv
// Testbench of the link error monitor: reset values, thresholds,
// sync masks, auto-clear, queued events and the pattern test.
// Assumes slm_pkg, slm_error_monitor and slm_framer_model.
`timescale 1ns/1ns
`default_nettype none
module tb_serdes_link_error_monitor
  import slm_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [11:0] reg_addr_i = 12'h000;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [23:0] lane_err_i = 24'h000000;
  logic [2:0] irq_mask_i = 3'h1;
  logic en = 1'b0;
  logic [31:0] rnd = 32'h0000004b;
  logic [7:0] reg_rdata_o, kv, tf, pc, p, p0;
  logic reg_rvalid_o, sync_o, irq_o, ltm, wbad;
  logic [23:0] hit;
  logic [15:0] fdata;
  logic [1:0] fvalid;
  logic [7:0] expq[$];
  int fail_count = 0;
  int compares = 0;
  // ==========
  // Clock and design
  initial forever #5 clk_i = ~clk_i;
  slm_error_monitor #(.NUM_LANES(8), .CNT_W(8)) dut (.clk_i(clk_i), .rst_i(rst_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .lane_err_i(lane_err_i), .lane_data_i({rnd[15:0], rnd, fdata}),
    .lane_valid_i({6'h00, fvalid}), .irq_mask_i(irq_mask_i),
    .sync_request_out_o(sync_o), .irq_o(irq_o), .threshold_hit_o(hit),
    .alignment_multiframe_groups_o(kv), .link_test_mode_o(ltm),
    .lane_test_fail_o(tf));
  slm_framer_model fm (.clk_i(clk_i), .en_i(en), .sync_i(sync_o), .data_o(fdata),
    .valid_o(fvalid), .pulse_cnt_o(pc), .width_bad_o(wbad));
  // ==========
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    xs = y ^ (y << 5);
  endfunction
  task chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1)
    begin
      fail_count++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task test_done;
    $display("Mismatches %0d, compares %0d", fail_count, compares);
    if (fail_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [7:0] e);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    expq.push_back(e);
    @(negedge clk_i);
    reg_rd_i = 1'b0;
  endtask
  task err(input logic [23:0] v, input int n);
    repeat (n)
    begin
      @(negedge clk_i);
      lane_err_i = v;
      @(negedge clk_i);
      lane_err_i = 24'h000000;
    end
  endtask
  task idle(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // Configuration only while in soft reset
  task cfg(input logic [7:0] t, input logic [7:0] c, input logic [2:0] m);
    wr(ADDR_SOFT_RST, 8'h08);
    wr(ADDR_THR, t);
    wr(ADDR_CTRL, c);
    wr(ADDR_SMASK, {5'h00, m});
    wr(ADDR_SOFT_RST, 8'h00);
    p = pc;
  endtask
  // Random octets on the lanes left unchecked
  always @(negedge clk_i) rnd = xs(rnd);
  // Read answers against the oldest note
  always @(negedge clk_i)
  begin
    if (reg_rvalid_o === 1'b1)
    begin
      p0 = expq.pop_front();
      chk(reg_rdata_o === p0, "read data");
    end
  end
  // ==========
  // Main sequence
  initial
  begin
    repeat (20) @(negedge clk_i);
    rst_i = 1'b0;
    rd(ADDR_MF_CNT, MF_CNT_RST);
    rd(ADDR_THR, THR_RST);
    rd(ADDR_SMASK, {5'h00, SMASK_RST});
    rd(ADDR_SOFT_RST, 8'h00);
    rd(12'h47e, 8'h00);
    chk(kv === 8'h01, "mf count out");
    wr(ADDR_SOFT_RST, 8'h08);
    rd(ADDR_SOFT_RST, 8'h08);
    wr(ADDR_CTRL, 8'hdf);
    rd(ADDR_CTRL, 8'h98);
    wr(ADDR_MF_CNT, 8'h04);
    rd(ADDR_MF_CNT, 8'h04);
    chk(kv === 8'h04, "mf count out");
    wr(ADDR_CTRL, 8'h80);
    wr(ADDR_SOFT_RST, 8'h00);
    idle(2);
    chk(ltm === 1'b1, "link test mode");
    // Threshold two, then saturation
    cfg(8'h02, 8'h00, 3'h7);
    err(24'h000001, 2);
    idle(12);
    chk(hit === 24'h000001, "hit flag");
    chk(irq_o === 1'b1, "irq");
    chk(pc - p === 8'h01, "one pulse");
    err(24'h000001, 3);
    idle(12);
    chk(pc - p === 8'h01, "saturated");
    // Sync enable bit order
    cfg(8'h02, 8'h00, 3'h3);
    irq_mask_i = 3'h4;
    err(24'h000001, 2);
    idle(12);
    chk(pc === p, "masked disparity");
    chk(irq_o === 1'b0, "irq masked");
    err(24'h000002, 2);
    idle(12);
    chk(pc - p === 8'h01, "table pulse");
    // Auto-clear touches only the cause
    cfg(8'h02, 8'h08, 3'h7);
    err(24'h000002, 1);
    err(24'h000001, 2);
    idle(12);
    chk(hit[0] === 1'b0, "cleared");
    err(24'h000002, 1);
    idle(12);
    chk(pc - p === 8'h02, "table kept");
    // Two lanes at once, plain then queued
    for (int q = 0; q < 2; q++)
    begin
      cfg(8'h01, q ? 8'h10 : 8'h00, 3'h7);
      err(24'h000009, 1);
      idle(30);
      chk(pc - p === 8'(q + 1), "event count");
    end
    // Pattern test, link test mode off
    cfg(8'hff, 8'h20, 3'h7);
    en = 1'b1;
    idle(20);
    chk(tf === 8'h02, "pattern fail");
    en = 1'b0;
    chk(wbad === 1'b0, "pulse width");
    test_done;
  end
  // Watchdog
  initial
  begin
    #100000;
    fail_count++;
    test_done;
  end
endmodule // tb_serdes_link_error_monitor
`default_nettype wire
